// ---- design/fsf_pkg.sv ----
/*
  Constants, register map and carrier types for the FIFO status block.
  Assumes one 40 MHz clock and a plain register port of 32-bit words.
*/
package fsf_pkg;

  // ==========================================================================
  // Geometry and thresholds
  // ==========================================================================
  localparam int          DATA_W    = 8;
  localparam int          DEPTH     = 16;
  localparam int          PTR_W     = 4;
  localparam int          CNT_W     = 5;
  localparam logic [4:0]  DEPTH_CNT = 5'h10;
  localparam logic [4:0]  AFULL_THR = 5'h0C;
  localparam logic [4:0]  AEMPTY_THR = 5'h04;

  // ==========================================================================
  // Register map, byte addresses
  // ==========================================================================
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0C;

  localparam int          CTRL_UDF_BIT = 0;
  localparam int          CTRL_OVF_BIT = 1;
  localparam int          CTRL_INJ_BIT = 2;
  localparam logic [2:0]  CTRL_RST     = 3'h3;

  localparam int          IRQ_UDF_BIT   = 0;
  localparam int          IRQ_OVF_BIT   = 1;
  localparam int          IRQ_ECC_BIT   = 2;
  localparam int          IRQ_AFULL_BIT = 3;
  localparam int          IRQ_W         = 4;
  localparam logic [3:0]  IRQ_RST       = 4'h0;

  // ==========================================================================
  // Error status codes
  // ==========================================================================
  localparam logic [1:0]  ECC_OK     = 2'h0;
  localparam logic [1:0]  ECC_FIXED  = 2'h2;
  localparam logic [1:0]  ECC_UNCORR = 2'h3;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic             full;
    logic             almostFull;
    logic             empty;
    logic             almostEmpty;
    logic [CNT_W-1:0] used;
  } fsf_stat_t;

  // Derives every flag from one word count.
  function automatic fsf_stat_t fsf_flags(input logic [CNT_W-1:0] cnt);
    fsf_stat_t s;
    s.full        = (cnt == DEPTH_CNT);
    s.almostFull  = (cnt >= AFULL_THR);
    s.empty       = (cnt == 5'h00);
    s.almostEmpty = (cnt < AEMPTY_THR);
    s.used        = cnt;
    return s;
  endfunction : fsf_flags

  localparam fsf_stat_t   STAT_RST = fsf_flags(5'h00);

endpackage : fsf_pkg

// ---- design/fsf_fifo_status.sv ----
/*
  Single-clock FIFO with registered status flags, fill counts, a two-bit
  read error status and a small register port with interrupt.
  Assumes all inputs synchronous to clk and a master that keeps strobes one
  cycle long and never both at once.
*/
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module fsf_fifo_status
  import fsf_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               sclr,
  input  wire logic               wrReq,
  input  wire logic [DATA_W-1:0]  wrData,
  input  wire logic               rdReq,
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWrData,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output fsf_stat_t               stat_r,
  output logic                    wrEmpty_r,
  output logic [CNT_W-1:0]        wrUsed_r,
  output logic [DATA_W-1:0]       rdData_r,
  output logic [1:0]              eccStatus_r,
  output logic [31:0]             regRdData_r,
  output logic                    irq_r
);

  // ==========================================================================
  // Storage and pointers
  // ==========================================================================
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DEPTH-1:0]  parity_r;
  logic [PTR_W-1:0]  wrPtr_r;
  logic [PTR_W-1:0]  rdPtr_r;
  logic [2:0]        ctrl_r;
  logic [IRQ_W-1:0]  irqStat_r;
  logic [IRQ_W-1:0]  irqMask_r;
  logic              wrOk;
  logic              rdOk;
  logic              udfHit;
  logic              ovfHit;
  logic              eccHit;
  logic              afullRise;
  logic [CNT_W-1:0]  cntNxt;
  fsf_stat_t         statNxt;
  logic [IRQ_W-1:0]  irqSet;
  logic [IRQ_W-1:0]  irqClr;

  assign rdOk   = rdReq && !(ctrl_r[CTRL_UDF_BIT] && stat_r.empty);
  assign wrOk   = wrReq && !(ctrl_r[CTRL_OVF_BIT] && stat_r.full);
  assign udfHit = rdReq && stat_r.empty;
  assign ovfHit = wrReq && stat_r.full;
  assign eccHit = rdOk && ((^mem[rdPtr_r]) != parity_r[rdPtr_r]);
  assign cntNxt = stat_r.used + {{(CNT_W-1){1'b0}}, wrOk} - {{(CNT_W-1){1'b0}}, rdOk};
  assign statNxt = fsf_flags(cntNxt);
  assign afullRise = statNxt.almostFull && !stat_r.almostFull;

  // The injection bit flips the low data bit of the next stored word while
  // the parity keeps the true value, so the read of it reports an error.
  always_ff @(posedge clk) begin
    if (wrOk) begin
      mem[wrPtr_r]      <= wrData ^ {{(DATA_W-1){1'b0}}, ctrl_r[CTRL_INJ_BIT]};
      parity_r[wrPtr_r] <= ^wrData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else if (sclr) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (wrOk) begin
        wrPtr_r <= wrPtr_r + 4'h1;
      end
      if (rdOk) begin
        rdPtr_r <= rdPtr_r + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Status flags and counts
  // ==========================================================================
  // Flags from next count.
  // Synchronous clear loads the reset flags on the next edge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= STAT_RST;
    end else if (sclr) begin
      stat_r <= STAT_RST;
    end else begin
      stat_r <= statNxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrEmpty_r <= STAT_RST.empty;
      wrUsed_r  <= STAT_RST.used;
    end else if (sclr) begin
      wrEmpty_r <= STAT_RST.empty;
      wrUsed_r  <= STAT_RST.used;
    end else begin
      wrEmpty_r <= stat_r.empty;
      wrUsed_r  <= stat_r.used;
    end
  end

  // ==========================================================================
  // Read data and error status
  // ==========================================================================
  // Error code per read.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_r    <= '0;
      eccStatus_r <= ECC_OK;
    end else if (sclr) begin
      rdData_r    <= '0;
      eccStatus_r <= ECC_OK;
    end else if (rdOk) begin
      rdData_r    <= mem[rdPtr_r];
      eccStatus_r <= eccHit ? ECC_UNCORR : ECC_OK;
    end
  end

  // ==========================================================================
  // Register port and interrupt
  // ==========================================================================
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
    end else if (regWr && regAddr == ADDR_CTRL) begin
      ctrl_r <= regWrData[2:0];
    end else if (wrOk) begin
      ctrl_r[CTRL_INJ_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqMask_r <= IRQ_RST;
    end else if (regWr && regAddr == ADDR_IRQ_MASK) begin
      irqMask_r <= regWrData[IRQ_W-1:0];
    end
  end

  assign irqSet = {afullRise, eccHit, ovfHit, udfHit};
  assign irqClr = (regWr && regAddr == ADDR_IRQ_STAT) ? regWrData[IRQ_W-1:0] : '0;

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqStat_r <= IRQ_RST;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irqStat_r & irqMask_r);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData_r <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        ADDR_CTRL:     regRdData_r <= {29'h0000_0000, ctrl_r};
        ADDR_STATUS:   regRdData_r <= {23'h00_0000, stat_r.used, stat_r.full,
                                       stat_r.almostFull, stat_r.empty,
                                       stat_r.almostEmpty};
        ADDR_IRQ_STAT: regRdData_r <= {28'h000_0000, irqStat_r};
        ADDR_IRQ_MASK: regRdData_r <= {28'h000_0000, irqMask_r};
        default:       regRdData_r <= 32'h0000_0000;
      endcase
    end else begin
      regRdData_r <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wrOnly;
    wrReq && !rdReq && !sclr && !stat_r.full;
  endsequence

  sequence s_rdOnEmpty;
    rdReq && !wrReq && !sclr && stat_r.empty && ctrl_r[CTRL_UDF_BIT];
  endsequence

  property p_empty;
    stat_r.empty == (stat_r.used == 5'h00);
  endproperty
  a_empty: assert property (p_empty) else $error("empty flag disagrees with count");

  property p_wrEmpty;
    !sclr |=> wrEmpty_r == $past(stat_r.empty);
  endproperty
  a_wrEmpty: assert property (p_wrEmpty) else $error("write-side empty not delayed");

  property p_almostFull;
    stat_r.almostFull == (stat_r.used >= AFULL_THR);
  endproperty
  a_almostFull: assert property (p_almostFull) else $error("almost-full wrong");

  property p_almostEmpty;
    stat_r.almostEmpty == (stat_r.used < AEMPTY_THR);
  endproperty
  a_almostEmpty: assert property (p_almostEmpty) else $error("almost-empty wrong");

  property p_countUp;
    s_wrOnly |=> stat_r.used == $past(stat_r.used) + 5'h01 ##1 wrUsed_r == $past(stat_r.used);
  endproperty
  a_countUp: assert property (p_countUp) else $error("count did not follow write");

  property p_underflow;
    s_rdOnEmpty |=> stat_r.empty && rdPtr_r == $past(rdPtr_r);
  endproperty
  a_underflow: assert property (p_underflow) else $error("read on empty not ignored");

  property p_clear;
    sclr |=> stat_r == STAT_RST ##1 wrEmpty_r;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left status set");

  property p_ecc;
    (eccStatus_r != 2'h1) and ($changed(eccStatus_r) |-> ($past(rdOk) || $past(sclr)));
  endproperty
  a_ecc: assert property (p_ecc) else $error("illegal or stray error code");

  property p_irq;
    (|(irqStat_r & irqMask_r)) |=> irq_r;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule : fsf_fifo_status

// ---- verif/fsf_user_model.sv ----
/*
  User logic that writes and reads the FIFO for the bench.
  Assumes the bench raises wantWr and wantRd within the FIFO capacity.
*/
`timescale 1ns/1ps
module fsf_user_model
  import fsf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire fsf_stat_t         stat,
  input  wire logic [DATA_W-1:0] rdData,
  input  wire logic [1:0]        ecc,
  input  wire logic              wantWr,
  input  wire logic              wantRd,
  input  wire logic              noGate,
  input  wire logic [DATA_W-1:0] wrByte,
  output logic                   wrReq,
  output logic [DATA_W-1:0]      wrData,
  output logic                   rdReq,
  output logic                   gotStb,
  output logic [DATA_W-1:0]      gotData,
  output logic [1:0]             gotEcc
);
  logic rdPend;

  // ==========================================================================
  // Requests
  // ==========================================================================
  // flag gated requests
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrReq <= 1'b0;
      rdReq <= 1'b0;
      wrData <= '0;
    end else begin
      wrReq <= wantWr && (noGate || !stat.full);
      rdReq <= wantRd && (noGate || !stat.empty);
      wrData <= wantWr ? wrByte : ~wrData;
    end
  end

  // ==========================================================================
  // Capture
  // ==========================================================================
  // fixed latency capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdPend <= 1'b0;
      gotStb <= 1'b0;
      gotData <= '0;
      gotEcc <= '0;
    end else begin
      rdPend <= rdReq;
      gotStb <= rdPend;
      gotData <= rdData;
      gotEcc <= ecc;
    end
  end
endmodule : fsf_user_model

// ---- verif/fsf_fifo_status_tb.sv ----
/*
  Self-checking bench for the FIFO status block.
  Assumes the user model fsf_user_model and a 40 MHz clock.
*/
`timescale 1ns/1ps
module fsf_fifo_status_tb;
  import fsf_pkg::*;
  logic              clk, rstn, sclr, wantWr, wantRd, noGate, wrReq, rdReq, gotStb;
  logic              wrEmpty, regWr, regRd, irq;
  logic [DATA_W-1:0] wrByte, wrData, rdData, gotData;
  logic [1:0]        ecc, gotEcc;
  logic [CNT_W-1:0]  wrUsed;
  logic [7:0]        regAddr;
  logic [31:0]       regWrData, regRdData;
  fsf_stat_t         stat;
  int                errors = 0;
  int                checksDone = 0;
  int                cycles = 0;

  fsf_fifo_status fsf_fifo_status_inst (
    .clk(clk), .rstn(rstn), .sclr(sclr), .wrReq(wrReq), .wrData(wrData), .rdReq(rdReq),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .stat_r(stat), .wrEmpty_r(wrEmpty), .wrUsed_r(wrUsed), .rdData_r(rdData),
    .eccStatus_r(ecc), .regRdData_r(regRdData), .irq_r(irq)
  );
  fsf_user_model fsf_user_model_inst (
    .clk(clk), .rstn(rstn), .stat(stat), .rdData(rdData), .ecc(ecc), .wantWr(wantWr),
    .wantRd(wantRd), .noGate(noGate), .wrByte(wrByte), .wrReq(wrReq), .wrData(wrData),
    .rdReq(rdReq), .gotStb(gotStb), .gotData(gotData), .gotEcc(gotEcc)
  );

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic complete_run();
    if (errors == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic cmpVal(input string what, input logic [31:0] expv, input logic [31:0] got);
    checksDone++;
    if (got !== expv) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, expv, got);
    end
  endtask : cmpVal

  task automatic cmpStat(input int n);
    fsf_stat_t s;
    s = '{full: n == DEPTH, almostFull: n >= AFULL_THR, empty: n == 0,
          almostEmpty: n < AEMPTY_THR, used: CNT_W'(n)};
    cmpVal("status", 32'(s), 32'(stat));
    @(posedge clk);
    #1;
    cmpVal("write side", 32'({n == 0, CNT_W'(n)}), 32'({wrEmpty, wrUsed}));
  endtask : cmpStat

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : regWrite

  task automatic regCheck(input string what, input logic [7:0] a, input logic [31:0] expv);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    cmpVal(what, expv, regRdData);
  endtask : regCheck

  task automatic pushN(input int cnt, input logic [7:0] base);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk);
      wantWr <= 1'b1;
      wrByte <= base + 8'(i);
    end
    @(posedge clk);
    wantWr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pushN

  task automatic popN(input int cnt, input logic [7:0] base, input logic [1:0] code);
    int k = 0;
    fork
      begin
        repeat (cnt) @(posedge clk) wantRd <= 1'b1;
        @(posedge clk);
        wantRd <= 1'b0;
      end
      while (k < cnt) begin
        @(posedge clk);
        #1;
        if (gotStb === 1'b1) begin
          if (code === ECC_OK) cmpVal("read data", base + 8'(k), gotData);
          cmpVal("error status", code, gotEcc);
          k++;
        end
      end
    join
    repeat (2) @(posedge clk);
    #1;
  endtask : popN

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic fillDrain();
    int steps[5] = '{3, 1, 7, 1, 4};
    int n = 0;
    foreach (steps[i]) begin
      pushN(steps[i], 8'(n));
      n += steps[i];
      cmpStat(n);
    end
    regCheck("status reg", ADDR_STATUS, 32'h0000_010C);
    @(posedge clk);
    noGate <= 1'b1;
    pushN(1, 8'hEE);
    @(posedge clk);
    noGate <= 1'b0;
    cmpStat(16);
    regCheck("irq status", ADDR_IRQ_STAT, 32'h0000_000A);
    popN(16, 8'h00, ECC_OK);
    cmpStat(0);
  endtask : fillDrain

  task automatic underflowIrq();
    @(posedge clk);
    wantRd <= 1'b1;
    noGate <= 1'b1;
    @(posedge clk);
    wantRd <= 1'b0;
    noGate <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmpStat(0);
    cmpVal("irq masked", 32'h0000_0000, 32'(irq));
    regCheck("irq status", ADDR_IRQ_STAT, 32'h0000_000B);
    regWrite(ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1;
    cmpVal("irq raised", 32'h0000_0001, 32'(irq));
    regWrite(ADDR_IRQ_STAT, 32'h0000_000F);
    repeat (2) @(posedge clk);
    #1;
    cmpVal("irq cleared", 32'h0000_0000, 32'(irq));
    regCheck("irq status", ADDR_IRQ_STAT, 32'h0000_0000);
  endtask : underflowIrq

  task automatic eccInject();
    regWrite(ADDR_CTRL, 32'h0000_0007);
    pushN(2, 8'h5A);
    popN(1, 8'h5A, ECC_UNCORR);
    popN(1, 8'h5B, ECC_OK);
    regCheck("ctrl", ADDR_CTRL, 32'h0000_0003);
    regCheck("irq status", ADDR_IRQ_STAT, 32'h0000_0004);
  endtask : eccInject

  task automatic clearMid();
    pushN(5, 8'h30);
    @(posedge clk);
    sclr <= 1'b1;
    @(posedge clk);
    sclr <= 1'b0;
    #1;
    cmpStat(0);
    cmpVal("read out", 32'h0000_0000, 32'({ecc, rdData}));
    regCheck("unmapped", 8'h10, 32'h0000_0000);
  endtask : clearMid

  // ==========================================================================
  // Clock, timeout and main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Roughly twenty times the expected run length.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    rstn = 1'b0;
    {sclr, wantWr, wantRd, noGate, regWr, regRd, wrByte, regAddr, regWrData} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    #1;
    cmpStat(0);
    cmpVal("reset out", 32'h0000_0000, 32'({irq, ecc, rdData}));
    regCheck("ctrl", ADDR_CTRL, 32'h0000_0003);
    fillDrain();
    underflowIrq();
    eccInject();
    clearMid();
    complete_run();
  end
endmodule : fsf_fifo_status_tb
